// ### inc/meter_seq_pkg.sv
// What this block does
// - multiple single-shot arms, then revert to hold
// - hold remote bus during multiple arming while commandQueueEnable low
// - latch setting: off is 0, on is 1
// - latch on clears stored trigger, mutes error
// - latch setting off after power-on
// - latch off: busy trigger flags error, dropped
// - latch on: keep first busy trigger, no error
// - stored trigger satisfies pending external event
// - latch serves arm, trigger and sample
// - reset command turns latch off
// - self-test fault sets bit 0 and aux bit
// - error output high while error bits set
// - timer source inserts interval between readings
// - interval up to 6000 s, 100 ns steps
// - default interval is one second
// - first timed reading starts without waiting
// - autorange suspended while timer source selected
// - sweep and count exclusive; sweep selects timer
// - after reset use reading count definition
// - terminal codes 0,1,2; error on mismatch
// - single beep, then beep enable unchanged
// - external arm select clears stored trigger only while latch on
// - arm, then trigger, then sample, in order
// - arm count 0 or 1 means one arm
package meter_seq_pkg;
  localparam int CLK_NS = 25;
  localparam int TICK_NS = 100;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int TICK_W = 36;
  localparam int MAX_INTERVAL_S = 6000;
  localparam logic [TICK_W-1:0] MAX_TICKS = TICK_W'(64'd6000 * 64'd10000000);
  localparam logic [TICK_W-1:0] RST_INTERVAL = TICK_W'(64'd10000000);
  localparam int ARM_W = 32;
  localparam int RDG_W = 24;
  localparam logic [RDG_W-1:0] RST_READINGS = 24'h000001;
  localparam logic [RDG_W-1:0] RST_SWEEP_RDGS = 24'h000400;
  localparam logic HOLD_OFF = 1'b0;
  localparam logic HOLD_ON = 1'b1;
  localparam int ERR_W = 16;
  localparam int ERR_HW_BIT = 0;
  localparam int ERR_TERM_BIT = 1;
  localparam int ERR_EARLY_BIT = 2;
  localparam logic [1:0] TERM_OPEN = 2'h0;
  localparam logic [1:0] TERM_FRONT = 2'h1;
  localparam logic [1:0] TERM_REAR = 2'h2;
  localparam int TONE_NS = 100000;
  localparam int TONE_CYC = TONE_NS / CLK_NS;

  typedef enum logic [2:0] {SRC_AUTO, SRC_EXT, SRC_SGL, SRC_HOLD, SRC_TIMER} src_e;

  typedef struct packed {
    logic armSel;
    src_e armSrc;
    logic [ARM_W-1:0] armCount;
    logic trigSel;
    src_e trigSrc;
    logic countSel;
    src_e sampleSrc;
    logic [RDG_W-1:0] readings;
    logic sweepSel;
    logic timerSel;
    logic [TICK_W-1:0] interval;
    logic holdSel;
    logic holdVal;
    logic resetCmd;
    logic termSel;
    logic [1:0] termCode;
    logic toneCmd;
  } cmd_s;

  typedef struct packed {
    logic arm;
    logic trig;
    logic sample;
  } events_s;
endpackage : meter_seq_pkg

// ### logic/meter_trigger_sequencer.sv
`timescale 1ns/1ps
module meter_trigger_sequencer #(
  parameter logic [meter_seq_pkg::TICK_W-1:0] MIN_TICKS = 36'h0000000c8,
  parameter logic [meter_seq_pkg::TICK_W-1:0] DEF_INTERVAL = meter_seq_pkg::RST_INTERVAL
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // commands from the remote controller; cmd and errClear are one-cycle strobes
  input wire meter_seq_pkg::cmd_s cmd,
  input wire logic commandQueueEnable,
  input wire logic autoRangeReq,
  input wire logic beepEnable,
  input wire logic errClear,
  // self-test result
  input wire logic selfTestFault,
  input wire logic [meter_seq_pkg::ERR_W-1:0] selfTestAux,
  // analog side
  input wire logic readingDone,
  // pins
  input wire logic extTrigPin,
  input wire logic termSwitchRear,
  // outputs
  output meter_seq_pkg::events_s events,
  output logic readingBusy,
  output logic busHold,
  output logic autoRangeActive,
  output logic beeper,
  output logic useSweep,
  output logic [meter_seq_pkg::ERR_W-1:0] errorReg,
  output logic [meter_seq_pkg::ERR_W-1:0] auxErrorReg,
  output logic errorIndicator,
  output logic holdEnable,
  output logic storedTrigger
);
  generate
    if (MIN_TICKS == '0 || MIN_TICKS > DEF_INTERVAL || DEF_INTERVAL > meter_seq_pkg::MAX_TICKS) begin : g_bad
      $error("interval limits out of range");
    end
    if (meter_seq_pkg::TICK_CYC < 1) begin : g_badtick
      $error("tick shorter than clock");
    end
  endgenerate
  typedef enum logic [1:0] {ST_ARM, ST_TRIG, ST_SAMPLE, ST_READ} state_e;
  logic initAll;
  logic [2:0] pinSync_r;
  logic [1:0] termSync_r;
  logic extFall;
  state_e state_r;
  meter_seq_pkg::src_e armSrc_r, trigSrc_r, sampleSrc_r;
  logic [meter_seq_pkg::ARM_W-1:0] armsLeft_r;
  logic multiArm_r;
  logic [meter_seq_pkg::RDG_W-1:0] rdgCount_r, sweepCount_r, rdgLeft_r;
  logic [meter_seq_pkg::TICK_W-1:0] timerIval_r, sweepIval_r, timerCnt_r;
  logic [7:0] tickDiv_r;
  logic tick;
  logic firstRdg_r;
  logic extAvail, armOk, trigOk, sampleOk, extUsed, cycleDone;
  logic [31:0] toneCnt_r;
  logic [meter_seq_pkg::TICK_W-1:0] ival;
  // settings return to power-on values on either reset
  assign initAll = ~rstn | cmd.resetCmd;
  // pins cross two flops before use; third stage only for edge detection
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pinSync_r <= 3'h7;
      termSync_r <= 2'h0;
    end else begin
      pinSync_r <= {pinSync_r[1:0], extTrigPin};
      termSync_r <= {termSync_r[0], termSwitchRear};
    end
  end
  assign extFall = pinSync_r[2] & ~pinSync_r[1];
  assign readingBusy = (state_r == ST_READ);
  // hold latch setting and stored trigger flag
  always_ff @(posedge clk) begin
    if (initAll) begin
      holdEnable <= meter_seq_pkg::HOLD_OFF;
    end else if (cmd.holdSel) begin
      holdEnable <= cmd.holdVal;
    end
  end
  always_ff @(posedge clk) begin
    if (initAll) begin
      storedTrigger <= 1'b0;
    end else if (extFall && readingBusy && holdEnable) begin
      storedTrigger <= 1'b1; // a pin edge beats a same-cycle clear, so none is lost
    end else if (cmd.holdSel && cmd.holdVal == meter_seq_pkg::HOLD_ON) begin
      storedTrigger <= 1'b0;
    end else if (cmd.armSel && cmd.armSrc == meter_seq_pkg::SRC_EXT && holdEnable) begin
      storedTrigger <= 1'b0;
    end else if (extUsed) begin
      storedTrigger <= 1'b0;
    end
  end

  // an external event is usable only between readings
  assign extAvail = ~readingBusy & (extFall | storedTrigger);
  assign armOk = (armSrc_r == meter_seq_pkg::SRC_AUTO) |
                 (armSrc_r == meter_seq_pkg::SRC_EXT & extAvail) |
                 (armSrc_r == meter_seq_pkg::SRC_SGL & armsLeft_r != '0);
  assign trigOk = (trigSrc_r == meter_seq_pkg::SRC_AUTO) |
                  (trigSrc_r == meter_seq_pkg::SRC_EXT & extAvail) |
                  (trigSrc_r == meter_seq_pkg::SRC_SGL);
  assign sampleOk = (sampleSrc_r == meter_seq_pkg::SRC_AUTO) |
                    (sampleSrc_r == meter_seq_pkg::SRC_EXT & extAvail) |
                    (sampleSrc_r == meter_seq_pkg::SRC_TIMER & (firstRdg_r | timerCnt_r == '0));
  assign extUsed = (state_r == ST_ARM & armSrc_r == meter_seq_pkg::SRC_EXT & extAvail) |
                   (state_r == ST_TRIG & trigSrc_r == meter_seq_pkg::SRC_EXT & extAvail) |
                   (state_r == ST_SAMPLE & sampleSrc_r == meter_seq_pkg::SRC_EXT & extAvail);
  assign cycleDone = readingBusy & readingDone & (rdgLeft_r <= 24'h000001);

  // arm, trigger, sample, read, strictly in order
  always_ff @(posedge clk) begin
    if (initAll) begin
      state_r <= ST_ARM;
    end else begin
      case (state_r)
        ST_ARM: if (armOk) state_r <= ST_TRIG;
        ST_TRIG: if (trigOk) state_r <= ST_SAMPLE;
        ST_SAMPLE: if (sampleOk) state_r <= ST_READ;
        ST_READ: if (readingDone) state_r <= cycleDone ? ST_ARM : ST_SAMPLE;
        default: state_r <= ST_ARM;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (initAll) begin
      events <= '0;
    end else begin
      events.arm <= (state_r == ST_ARM) & armOk;
      events.trig <= (state_r == ST_TRIG) & trigOk;
      events.sample <= (state_r == ST_SAMPLE) & sampleOk;
    end
  end

  // arm source and multiple arming
  always_ff @(posedge clk) begin
    if (initAll) begin
      armSrc_r <= meter_seq_pkg::SRC_AUTO;
      armsLeft_r <= '0;
      multiArm_r <= 1'b0;
    end else if (cmd.armSel) begin
      armSrc_r <= cmd.armSrc;
      if (cmd.armSrc == meter_seq_pkg::SRC_SGL) begin
        armsLeft_r <= (cmd.armCount <= 32'h00000001) ? 32'h00000001 : cmd.armCount;
        multiArm_r <= (cmd.armCount > 32'h00000001);
      end else begin
        armsLeft_r <= '0;
        multiArm_r <= 1'b0;
      end
    end else begin
      if (state_r == ST_ARM && armOk && armSrc_r == meter_seq_pkg::SRC_SGL) begin
        armsLeft_r <= armsLeft_r - 32'h00000001;
      end
      if (cycleDone && armSrc_r == meter_seq_pkg::SRC_SGL && armsLeft_r == '0) begin
        armSrc_r <= meter_seq_pkg::SRC_HOLD;
        multiArm_r <= 1'b0;
      end
    end
  end

  // while commandQueueEnable is low, the bus stays held until the last cycle of a multiple arm ends
  assign busHold = multiArm_r & ~commandQueueEnable;

  // trigger source; single trigger reverts to hold once used
  always_ff @(posedge clk) begin
    if (initAll) begin
      trigSrc_r <= meter_seq_pkg::SRC_AUTO;
    end else if (cmd.trigSel) begin
      trigSrc_r <= cmd.trigSrc;
    end else if (state_r == ST_TRIG && trigSrc_r == meter_seq_pkg::SRC_SGL) begin
      trigSrc_r <= meter_seq_pkg::SRC_HOLD;
    end
  end

  // sample definition: last of count or sweep wins
  always_ff @(posedge clk) begin
    if (initAll) begin
      sampleSrc_r <= meter_seq_pkg::SRC_AUTO;
      rdgCount_r <= meter_seq_pkg::RST_READINGS;
      sweepCount_r <= meter_seq_pkg::RST_SWEEP_RDGS;
      sweepIval_r <= MIN_TICKS;
      useSweep <= 1'b0;
    end else if (cmd.sweepSel) begin
      if (cmd.readings != '0 && cmd.interval >= MIN_TICKS && cmd.interval <= meter_seq_pkg::MAX_TICKS) begin
        sweepCount_r <= cmd.readings;
        sweepIval_r <= cmd.interval;
        sampleSrc_r <= meter_seq_pkg::SRC_TIMER;
        useSweep <= 1'b1;
      end
    end else if (cmd.countSel) begin
      if (cmd.readings != '0) begin
        rdgCount_r <= cmd.readings;
        sampleSrc_r <= cmd.sampleSrc;
        useSweep <= 1'b0;
      end
    end
  end

  // timer interval in 100 ns ticks; out-of-range requests are ignored
  always_ff @(posedge clk) begin
    if (initAll) begin
      timerIval_r <= DEF_INTERVAL;
    end else if (cmd.timerSel && cmd.interval >= MIN_TICKS && cmd.interval <= meter_seq_pkg::MAX_TICKS) begin
      timerIval_r <= cmd.interval;
    end
  end

  assign ival = useSweep ? sweepIval_r : timerIval_r;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tickDiv_r <= '0;
    end else if (tick || (state_r == ST_SAMPLE && sampleOk)) begin
      tickDiv_r <= '0; // restart the phase at each reload so the interval is whole
    end else begin
      tickDiv_r <= tickDiv_r + 8'h01;
    end
  end
  assign tick = (tickDiv_r == 8'(meter_seq_pkg::TICK_CYC - 1));
  // reload at each reading start, count down on ticks
  always_ff @(posedge clk) begin
    if (initAll) begin
      timerCnt_r <= '0;
    end else if (state_r == ST_SAMPLE && sampleOk) begin
      timerCnt_r <= ival;
    end else if (tick && timerCnt_r != '0) begin
      timerCnt_r <= timerCnt_r - 36'h000000001;
    end
  end

  // first reading after a trigger does not wait
  always_ff @(posedge clk) begin
    if (initAll) begin
      firstRdg_r <= 1'b1;
    end else if (state_r == ST_TRIG && trigOk) begin
      firstRdg_r <= 1'b1;
    end else if (state_r == ST_SAMPLE && sampleOk) begin
      firstRdg_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (initAll) begin
      rdgLeft_r <= '0;
    end else if (state_r == ST_TRIG && trigOk) begin
      rdgLeft_r <= useSweep ? sweepCount_r : rdgCount_r;
    end else if (readingBusy && readingDone) begin
      rdgLeft_r <= rdgLeft_r - 24'h000001;
    end
  end

  assign autoRangeActive = autoRangeReq & (sampleSrc_r != meter_seq_pkg::SRC_TIMER);

  // error registers: hardware set wins over software clear
  always_ff @(posedge clk) begin
    if (!rstn) begin
      errorReg <= '0;
      auxErrorReg <= '0;
    end else begin
      if (errClear) begin
        errorReg <= '0;
        auxErrorReg <= '0;
      end
      if (selfTestFault) begin
        errorReg[meter_seq_pkg::ERR_HW_BIT] <= 1'b1;
        auxErrorReg <= (errClear ? '0 : auxErrorReg) | selfTestAux;
      end
      if (cmd.termSel && (cmd.termCode == meter_seq_pkg::TERM_OPEN || cmd.termCode > meter_seq_pkg::TERM_REAR ||
          (cmd.termCode == meter_seq_pkg::TERM_FRONT && termSync_r[1]) ||
          (cmd.termCode == meter_seq_pkg::TERM_REAR && !termSync_r[1]))) begin
        errorReg[meter_seq_pkg::ERR_TERM_BIT] <= 1'b1;
      end
      if (extFall && readingBusy && !holdEnable) begin
        errorReg[meter_seq_pkg::ERR_EARLY_BIT] <= 1'b1;
      end
    end
  end
  assign errorIndicator = |errorReg;

  // tone sounds regardless of beep enable, which it never touches
  always_ff @(posedge clk) begin
    if (!rstn) begin
      toneCnt_r <= '0;
    end else if (cmd.toneCmd) begin
      toneCnt_r <= 32'(meter_seq_pkg::TONE_CYC);
    end else if (toneCnt_r != '0) begin
      toneCnt_r <= toneCnt_r - 32'h00000001;
    end
  end
  assign beeper = (toneCnt_r != '0);

  // checks
  a_early_err_set: assert property (@(posedge clk) disable iff (!rstn)
    extFall && readingBusy && !holdEnable |=> errorReg[meter_seq_pkg::ERR_EARLY_BIT])
    else $error("early trigger not flagged");
  a_hold_no_err: assert property (@(posedge clk) disable iff (!rstn)
    holdEnable && !cmd.holdSel && !errClear && !errorReg[meter_seq_pkg::ERR_EARLY_BIT]
    |=> !errorReg[meter_seq_pkg::ERR_EARLY_BIT])
    else $error("early error raised with latch on");
  a_hold_on_clr: assert property (@(posedge clk) disable iff (!rstn)
    cmd.holdSel && cmd.holdVal && !cmd.resetCmd && !(extFall && readingBusy && holdEnable)
    |=> holdEnable && !storedTrigger)
    else $error("latch on did not clear");
  a_reset_off: assert property (@(posedge clk) disable iff (!rstn)
    cmd.resetCmd |=> !holdEnable && !useSweep)
    else $error("reset left latch or sweep");
  a_err_out: assert property (@(posedge clk) disable iff (!rstn)
    selfTestFault || (cmd.termSel && cmd.termCode == meter_seq_pkg::TERM_OPEN) |=> errorIndicator)
    else $error("error output not raised");
  a_hw_fault: assert property (@(posedge clk) disable iff (!rstn)
    selfTestFault |=> errorReg[meter_seq_pkg::ERR_HW_BIT] && (~auxErrorReg & $past(selfTestAux)) == '0)
    else $error("self-test fault not recorded");
  a_event_order: assert property (@(posedge clk) disable iff (!rstn)
    events.trig |-> $past(state_r) == ST_TRIG && !events.arm && !events.sample)
    else $error("trigger out of order");
  a_sweep_timer: assert property (@(posedge clk) disable iff (!rstn)
    cmd.sweepSel && !cmd.resetCmd && cmd.readings != '0 && cmd.interval >= MIN_TICKS
    && cmd.interval <= meter_seq_pkg::MAX_TICKS |=> useSweep && !autoRangeActive)
    else $error("sweep did not select timer");
  a_autorange: assert property (@(posedge clk) disable iff (!rstn)
    cmd.countSel && cmd.readings != '0 && !cmd.sweepSel && !cmd.resetCmd
    |=> autoRangeActive == (autoRangeReq && $past(cmd.sampleSrc) != meter_seq_pkg::SRC_TIMER))
    else $error("autorange not suspended or resumed");
  a_bus_hold: assert property (@(posedge clk) disable iff (!rstn)
    cycleDone && armsLeft_r == '0 && armSrc_r == meter_seq_pkg::SRC_SGL && !cmd.armSel && !cmd.resetCmd
    |=> !busHold && armSrc_r == meter_seq_pkg::SRC_HOLD)
    else $error("multiple arming did not end");
  a_timer_wait: assert property (@(posedge clk) disable iff (!rstn)
    state_r == ST_SAMPLE && sampleSrc_r == meter_seq_pkg::SRC_TIMER && !firstRdg_r && timerCnt_r != '0
    |-> !events.sample ##1 !events.sample)
    else $error("timed reading started early");
  c_multi_arm: cover property (@(posedge clk) disable iff (!rstn) busHold ##1 !busHold);
  c_stored_use: cover property (@(posedge clk) disable iff (!rstn) storedTrigger ##1 !storedTrigger);
  c_timed_read: cover property (@(posedge clk) disable iff (!rstn)
    events.sample && sampleSrc_r == meter_seq_pkg::SRC_TIMER && !firstRdg_r);
endmodule : meter_trigger_sequencer

// ### verif/meter_trigger_sequencer_test.sv
`timescale 1ns/1ps
module meter_trigger_sequencer_test;
  logic clk, rstn, commandQueueEnable, autoRangeReq, beepEnable, errClear, selfTestFault;
  logic readingDone, extTrigPin, termSwitchRear, readingBusy, busHold, autoRangeActive;
  logic beeper, useSweep, errorIndicator, holdEnable, storedTrigger, rear;
  meter_seq_pkg::cmd_s cmd, c;
  meter_seq_pkg::events_s events;
  logic [meter_seq_pkg::ERR_W-1:0] selfTestAux, errorReg, auxErrorReg, aux;
  logic [7:0] delayCyc;
  logic [31:0] seed = 32'h9de4;
  int errors = 0, n_tests = 0, cyc = 0, armCnt = 0, trigCnt = 0, trigT = 0, k, n, i;
  int sampT[$];

  // short interval and minimum so timed readings fit the run
  meter_trigger_sequencer #(.MIN_TICKS(36'h2), .DEF_INTERVAL(36'h14)) i_meter_trigger_sequencer (
    .clk(clk), .rstn(rstn), .cmd(cmd), .commandQueueEnable(commandQueueEnable),
    .autoRangeReq(autoRangeReq), .beepEnable(beepEnable), .errClear(errClear),
    .selfTestFault(selfTestFault), .selfTestAux(selfTestAux), .readingDone(readingDone),
    .extTrigPin(extTrigPin), .termSwitchRear(termSwitchRear), .events(events),
    .readingBusy(readingBusy), .busHold(busHold), .autoRangeActive(autoRangeActive),
    .beeper(beeper), .useSweep(useSweep), .errorReg(errorReg), .auxErrorReg(auxErrorReg),
    .errorIndicator(errorIndicator), .holdEnable(holdEnable), .storedTrigger(storedTrigger));

  reading_model i_reading_model (.clk(clk), .busy(readingBusy), .delayCyc(delayCyc), .done(readingDone));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (events.arm === 1'b1) armCnt++;
    if (events.trig === 1'b1) begin
      trigCnt++;
      trigT = cyc;
    end
    if (events.sample === 1'b1) sampT.push_back(cyc);
    if (cyc > 20000) begin
      errors++;
      test_done();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic term_err(logic [1:0] code, logic atRear);
    return (code == meter_seq_pkg::TERM_OPEN) || (code == meter_seq_pkg::TERM_FRONT && atRear) ||
           (code == meter_seq_pkg::TERM_REAR && !atRear) || (code > 2'h2);
  endfunction : term_err

  // checks happen 1 ns after an edge, once that edge's updates have landed
  task automatic tick(int cnt);
    repeat (cnt) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(logic [63:0] got, logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic issue(meter_seq_pkg::cmd_s v);
    @(posedge clk) cmd <= v;
    @(posedge clk) cmd <= '0;
    #1;
  endtask : issue

  task automatic clear_err();
    @(posedge clk) errClear <= 1'b1;
    @(posedge clk) errClear <= 1'b0;
    tick(1);
  endtask : clear_err

  // falling edge on the pin, held long enough for the synchroniser
  task automatic ext_pulse();
    @(posedge clk) extTrigPin <= 1'b0;
    repeat (4) @(posedge clk);
    extTrigPin <= 1'b1;
    tick(6);
  endtask : ext_pulse

  task automatic wait_busy(logic v);
    for (int j = 0; j < 500 && readingBusy !== v; j++) tick(1);
  endtask : wait_busy

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  initial begin
    cmd = '0;
    rstn = 1'b0;
    commandQueueEnable = 1'b0;
    autoRangeReq = 1'b1;
    beepEnable = 1'b1;
    errClear = 1'b0;
    selfTestFault = 1'b0;
    selfTestAux = '0;
    extTrigPin = 1'b1;
    termSwitchRear = 1'b0;
    delayCyc = 8'd5;
    tick(1);
    chk(holdEnable, meter_seq_pkg::HOLD_OFF);
    chk(useSweep, 1'b0);
    chk(errorIndicator, 1'b0);
    @(posedge clk) rstn <= 1'b1;
    tick(8);
    chk(armCnt, 1);
    chk(sampT[0] - trigT, 1);
    $display("test reset done");

    aux = 16'(xs());
    @(posedge clk) begin
      selfTestFault <= 1'b1;
      selfTestAux <= aux;
    end
    @(posedge clk) selfTestFault <= 1'b0;
    tick(1);
    chk(errorReg[meter_seq_pkg::ERR_HW_BIT], 1'b1);
    chk(auxErrorReg, aux);
    chk(errorIndicator, 1'b1);
    clear_err();
    chk(errorIndicator, 1'b0);
    $display("test selftest done");

    for (k = 0; k < 6; k++) begin
      rear = 1'(xs());
      @(posedge clk) termSwitchRear <= rear;
      tick(4);
      clear_err();
      c = '0;
      c.termSel = 1'b1;
      c.termCode = 2'(k % 3);
      issue(c);
      chk(errorReg[meter_seq_pkg::ERR_TERM_BIT], term_err(2'(k % 3), rear));
    end
    $display("test terminal done");

    // slow readings so pin edges land inside one
    @(posedge clk) delayCyc <= 8'd60;
    clear_err();
    wait_busy(1'b0);
    wait_busy(1'b1);
    ext_pulse();
    chk(errorReg[meter_seq_pkg::ERR_EARLY_BIT], 1'b1);
    chk(holdEnable, meter_seq_pkg::HOLD_OFF);
    clear_err();
    wait_busy(1'b0);
    wait_busy(1'b1);
    c = '0;
    c.trigSel = 1'b1;
    c.trigSrc = meter_seq_pkg::SRC_EXT;
    issue(c);
    c = '0;
    c.holdSel = 1'b1;
    c.holdVal = meter_seq_pkg::HOLD_ON;
    issue(c);
    chk(holdEnable, meter_seq_pkg::HOLD_ON);
    ext_pulse();
    ext_pulse();
    chk(storedTrigger, 1'b1);
    chk(errorReg[meter_seq_pkg::ERR_EARLY_BIT], 1'b0);
    n = trigCnt;
    wait_busy(1'b0);
    tick(20);
    chk(trigCnt - n, 1);
    chk(storedTrigger, 1'b0);
    wait_busy(1'b1);
    ext_pulse();
    chk(storedTrigger, 1'b1);
    issue(c);
    chk(storedTrigger, 1'b0);
    ext_pulse();
    chk(storedTrigger, 1'b1);
    c = '0;
    c.armSel = 1'b1;
    c.armSrc = meter_seq_pkg::SRC_EXT;
    issue(c);
    chk(storedTrigger, 1'b0);
    c = '0;
    c.resetCmd = 1'b1;
    issue(c);
    chk(holdEnable, meter_seq_pkg::HOLD_OFF);
    $display("test trigger latch done");

    @(posedge clk) delayCyc <= 8'd3;
    c = '0;
    c.armSel = 1'b1;
    c.armSrc = meter_seq_pkg::SRC_HOLD;
    issue(c);
    tick(120);
    for (k = 3; k >= 0; k -= 3) begin
      n = armCnt;
      c.armSrc = meter_seq_pkg::SRC_SGL;
      c.armCount = 32'(k);
      issue(c);
      tick(2);
      chk(busHold, k > 1);
      @(posedge clk) commandQueueEnable <= 1'b1;
      tick(1);
      chk(busHold, 1'b0);
      @(posedge clk) commandQueueEnable <= 1'b0;
      tick(150);
      chk(armCnt - n, (k > 1) ? k : 1);
      chk(busHold, 1'b0);
    end
    $display("test multiple arming done");

    c = '0;
    c.countSel = 1'b1;
    c.sampleSrc = meter_seq_pkg::SRC_TIMER;
    c.readings = 24'h000003;
    issue(c);
    chk(autoRangeActive, 1'b0);
    c = '0;
    c.timerSel = 1'b1;
    c.interval = 36'ha;
    issue(c);
    for (k = 0; k < 2; k++) begin
      // second pass asks for an interval below the minimum, which must be ignored
      c = '0;
      c.timerSel = 1'b1;
      c.interval = 36'h1;
      if (k == 1) issue(c);
      sampT.delete();
      c = '0;
      c.armSel = 1'b1;
      c.armSrc = meter_seq_pkg::SRC_SGL;
      issue(c);
      tick(200);
      chk(sampT.size(), 3);
      chk(sampT[0] - trigT, 1);
      for (i = 1; i < 3; i++) chk(sampT[i] - sampT[i-1] inside {[40:46]}, 1'b1);
    end
    c = '0;
    c.countSel = 1'b1;
    c.sampleSrc = meter_seq_pkg::SRC_AUTO;
    c.readings = 24'h000001;
    issue(c);
    chk(autoRangeActive, 1'b1);
    $display("test interval timer done");

    c = '0;
    c.sweepSel = 1'b1;
    c.interval = 36'ha;
    c.readings = 24'h000002;
    issue(c);
    chk(useSweep, 1'b1);
    chk(autoRangeActive, 1'b0);
    c = '0;
    c.resetCmd = 1'b1;
    issue(c);
    chk(useSweep, 1'b0);
    $display("test sweep done");

    c = '0;
    c.toneCmd = 1'b1;
    issue(c);
    for (n = 0; n < 5000 && beeper === 1'b1; n++) tick(1);
    chk(n inside {[meter_seq_pkg::TONE_CYC-1:meter_seq_pkg::TONE_CYC+1]}, 1'b1);
    $display("test tone done");
    test_done();
  end
endmodule : meter_trigger_sequencer_test

// ### verif/reading_model.sv
`timescale 1ns/1ps
module reading_model (
  // clock
  input wire logic clk,
  // reading in progress and how long the analog side takes
  input wire logic busy,
  input wire logic [7:0] delayCyc,
  // completion, one-cycle pulse
  output logic done
);
  logic [7:0] cnt_r;

  // done only pulses inside a reading, so a stale pulse never cuts the next reading short
  always @(posedge clk) begin
    if (!busy || done) begin
      cnt_r <= 8'h00;
      done <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 8'h01;
      done <= (cnt_r == delayCyc);
    end
  end
endmodule : reading_model
